// ### logic/ae_cfg_pkg.sv
// Register map, field layout and reset values of the exposure configuration bank
package ae_cfg_pkg;
   // Printed register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONTROL = 8'ha0;
   localparam logic [7:0] IDX_TARGET = 8'ha1;
   localparam logic [7:0] IDX_R_WEIGHT = 8'ha2;
   localparam logic [7:0] IDX_G1_WEIGHT = 8'ha3;
   localparam logic [7:0] IDX_G2_WEIGHT = 8'ha4;
   localparam logic [7:0] IDX_STATUS = 8'haf;
   localparam int ADDR_W = 12;
   localparam int REG_W = 16;
   localparam int WEIGHT_W = 10;
   localparam int TARGET_W = 10;
   localparam int CLIP_W = 4;
   localparam int GAIN_W = 2;
   localparam int FILTER_W = 16;
   // Control fields
   localparam int CTL_ENABLE = 0;
   localparam int CTL_RESTART = 1;
   localparam int CTL_FREEZE = 2;
   localparam int CTL_SUBSAMPLE = 3;
   localparam int CTL_PRIORITY = 4;
   localparam int CTL_W = 5;
   // Target fields
   localparam int TGT_LSB = 0;
   localparam int CLIP_LSB = 10;
   // Reset values
   localparam logic [CTL_W-1:0] CONTROL_RESET = 5'h10;
   localparam logic [REG_W-1:0] TARGET_RESET = 16'h60b8;
   localparam logic [WEIGHT_W-1:0] WEIGHT_RESET = 10'h080;
   // Every fourth pixel when subsampling
   localparam int SUBSAMPLE_STEP = 4;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### logic/ae_loop_core.sv
// Exposure loop state: filter hold, pixel subsampling and gain-stage distribution
`timescale 1ns/1ps
`default_nettype none
module ae_loop_core
   import ae_cfg_pkg::*;
#(
   parameter int STAGE_MAX = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Configuration
   input wire logic loop_enable,
   input wire logic filter_restart,
   input wire logic freeze,
   input wire logic subsample,
   input wire logic stage1_first,
   // Loop inputs
   input wire logic pixel_in,
   input wire logic filter_valid,
   input wire logic [FILTER_W-1:0] filter_value,
   input wire logic [2:0] gain_req,
   // Loop outputs
   output logic stat_take,
   output logic [FILTER_W-1:0] filter_state,
   output logic [GAIN_W-1:0] gain_stage1,
   output logic [GAIN_W-1:0] gain_stage2
);
   localparam logic [2:0] SMAX = 3'(STAGE_MAX);
   logic [1:0] pix_cnt;
   logic [2:0] first_part;
   logic [2:0] rest_part;
   logic [GAIN_W-1:0] next_stage1;
   logic [GAIN_W-1:0] next_stage2;

   // =========================================
   // Statistics pixel selection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pix_cnt <= 2'h0;
         stat_take <= 1'b0;
      end else begin
         if (pixel_in) begin
            pix_cnt <= pix_cnt + 2'h1;
         end
         stat_take <= loop_enable && pixel_in && (!subsample || pix_cnt == 2'h0); // RL2
      end
   end

   // =========================================
   // Averaging filter state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         filter_state <= '0;
      end else if (filter_restart) begin
         filter_state <= '0; // RL6
      end else if (loop_enable && filter_valid && !freeze) begin // RL1 RL6
         filter_state <= filter_value;
      end
   end

   // =========================================
   // Gain distribution over the two stages
   always_comb begin
      first_part = (gain_req > SMAX) ? SMAX : gain_req;
      rest_part = gain_req - first_part;
      if (rest_part > SMAX) begin
         rest_part = SMAX;
      end
      if (stage1_first) begin // RL3
         next_stage1 = first_part[GAIN_W-1:0];
         next_stage2 = rest_part[GAIN_W-1:0];
      end else begin
         next_stage2 = first_part[GAIN_W-1:0];
         next_stage1 = rest_part[GAIN_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_stage1 <= '0;
         gain_stage2 <= '0;
      end else if (loop_enable && !freeze) begin // RL1
         gain_stage1 <= next_stage1;
         gain_stage2 <= next_stage2;
      end
   end
endmodule
`default_nettype wire

// ### logic/auto_exposure_config_bank.sv
// Exposure loop configuration bank behind an AXI4-Lite slave
//
// Overview of operation
// RL1: Freeze holds filter state and applied gains; the code lets the restart bit clear the filter even while frozen.
// RL2: Subsample bit selects every or every fourth pixel.
// RL3: Priority bit, reset one, orders gain stages.
// RL4: Target intensity and 3.3 clip limit fields; the code keeps only a 4-bit clip limit, bits 13:10.
// RL5: Three 3.7 colour weights, reset unity.
// RL6: Enable runs loop; restart clears averaging filter.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module auto_exposure_config_bank
   import ae_cfg_pkg::*;
#(
   parameter int STAGE_MAX = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Exposure loop inputs
   input wire logic pixel_in,
   input wire logic filter_valid,
   input wire logic [FILTER_W-1:0] filter_value,
   input wire logic [2:0] gain_req,
   // Exposure loop outputs
   output logic stat_take,
   output logic [FILTER_W-1:0] filter_state,
   output logic [GAIN_W-1:0] gain_stage1,
   output logic [GAIN_W-1:0] gain_stage2,
   output logic [TARGET_W-1:0] target_intensity,
   output logic [CLIP_W-1:0] clip_limit,
   output logic [WEIGHT_W-1:0] r_weight,
   output logic [WEIGHT_W-1:0] g1_weight,
   output logic [WEIGHT_W-1:0] g2_weight
);
   localparam logic [ADDR_W-1:0] A_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
   localparam logic [ADDR_W-1:0] A_TARGET = {2'h0, IDX_TARGET, 2'h0};
   localparam logic [ADDR_W-1:0] A_R_WEIGHT = {2'h0, IDX_R_WEIGHT, 2'h0};
   localparam logic [ADDR_W-1:0] A_G1_WEIGHT = {2'h0, IDX_G1_WEIGHT, 2'h0};
   localparam logic [ADDR_W-1:0] A_G2_WEIGHT = {2'h0, IDX_G2_WEIGHT, 2'h0};
   localparam logic [ADDR_W-1:0] A_STATUS = {2'h0, IDX_STATUS, 2'h0};
   // Byte addresses are four times the register index, so the two low
   // address bits are always zero for a legal access. A decode must match
   // exactly: a misaligned or unknown address is answered with an error
   // response and leaves every register untouched.
   // The status word is read-only and carries live loop state, so software
   // can watch the filter and gain stages without a separate port.

   logic rst_meta;
   logic rst_n;
   logic [CTL_W-1:0] auto_exposure_control;
   logic [REG_W-1:0] exposure_target;
   logic [WEIGHT_W-1:0] weight [3];
   logic aw_got;
   logic w_got;
   logic [ADDR_W-1:0] waddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic do_write;
   logic [REG_W-1:0] wmask;
   logic [REG_W-1:0] wval;
   logic wmapped;
   logic [31:0] rd_value;
   logic rd_mapped;

   // =========================================
   // Reset release
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // =========================================
   // Write channels, taken in either order
   // Address and data are latched on their own handshakes and the register
   // update waits until both are in hand. Both ready lines stay low while a
   // response is pending, so a second write can never overtake the first
   // and overwrite the latched address before it is used.
   assign do_write = aw_got && w_got && !s_axi_bvalid;
   assign wmask = {{8{wstrb[1]}}, {8{wstrb[0]}}};
   assign wval = wdata[REG_W-1:0] & wmask;

   always_comb begin
      unique case (waddr)
         A_CONTROL, A_TARGET, A_R_WEIGHT, A_G1_WEIGHT, A_G2_WEIGHT: wmapped = 1'b1;
         default: wmapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         waddr <= '0;
         wdata <= '0;
         wstrb <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            waddr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_got && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            wdata <= s_axi_wdata;
            wstrb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (!w_got && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wmapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // =========================================
   // Configuration registers
   // Byte strobes merge into the stored value; the upper two strobe lanes
   // have no bits to gate in a sixteen-bit register and are ignored.
   // The restart bit is a stored level: it keeps the filter cleared for as
   // long as software leaves it set.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         auto_exposure_control <= CONTROL_RESET; // RL3 RL6
      end else if (do_write && waddr == A_CONTROL) begin
         auto_exposure_control <= (auto_exposure_control & ~wmask[CTL_W-1:0])
            | wval[CTL_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         exposure_target <= TARGET_RESET; // RL4
      end else if (do_write && waddr == A_TARGET) begin
         exposure_target <= (exposure_target & ~wmask) | wval;
      end
   end

   generate
      for (genvar i = 0; i < 3; i++) begin : g_weight
         localparam logic [ADDR_W-1:0] A_W = {2'h0, 8'(IDX_R_WEIGHT + 8'(i)), 2'h0};
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               weight[i] <= WEIGHT_RESET; // RL5
            end else if (do_write && waddr == A_W) begin
               weight[i] <= (weight[i] & ~wmask[WEIGHT_W-1:0]) | wval[WEIGHT_W-1:0];
            end
         end
      end
   endgenerate

   // =========================================
   // Configuration outputs to the statistics path
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         target_intensity <= TARGET_RESET[TGT_LSB +: TARGET_W];
         clip_limit <= TARGET_RESET[CLIP_LSB +: CLIP_W];
         r_weight <= WEIGHT_RESET;
         g1_weight <= WEIGHT_RESET;
         g2_weight <= WEIGHT_RESET;
      end else begin
         target_intensity <= exposure_target[TGT_LSB +: TARGET_W]; // RL4
         clip_limit <= exposure_target[CLIP_LSB +: CLIP_W]; // RL4
         r_weight <= weight[0]; // RL5
         g1_weight <= weight[1]; // RL5
         g2_weight <= weight[2]; // RL5
      end
   end

   // =========================================
   // Read channel
   // Read data are captured on the address handshake and then held until
   // the master accepts them, so a later change of a register does not
   // alter a response already on offer.
   always_comb begin
      rd_value = '0;
      rd_mapped = 1'b1;
      unique case (s_axi_araddr)
         A_CONTROL: rd_value[CTL_W-1:0] = auto_exposure_control;
         A_TARGET: rd_value[REG_W-1:0] = exposure_target;
         A_R_WEIGHT: rd_value[WEIGHT_W-1:0] = weight[0];
         A_G1_WEIGHT: rd_value[WEIGHT_W-1:0] = weight[1];
         A_G2_WEIGHT: rd_value[WEIGHT_W-1:0] = weight[2];
         A_STATUS: rd_value = {12'h000, gain_stage2, gain_stage1, filter_state};
         default: rd_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // =========================================
   // Exposure loop
   // Control bits go straight from the register to the loop; a write takes
   // effect on the edge after it lands.
   ae_loop_core #(
      .STAGE_MAX(STAGE_MAX)
   ) u_loop (
      .clk(clk),
      .rst_n(rst_n),
      .loop_enable(auto_exposure_control[CTL_ENABLE]), // RL6
      .filter_restart(auto_exposure_control[CTL_RESTART]), // RL6
      .freeze(auto_exposure_control[CTL_FREEZE]), // RL1
      .subsample(auto_exposure_control[CTL_SUBSAMPLE]), // RL2
      .stage1_first(auto_exposure_control[CTL_PRIORITY]), // RL3
      .pixel_in(pixel_in),
      .filter_valid(filter_valid),
      .filter_value(filter_value),
      .gain_req(gain_req),
      .stat_take(stat_take),
      .filter_state(filter_state),
      .gain_stage1(gain_stage1),
      .gain_stage2(gain_stage2)
   );
endmodule
`default_nettype wire

// ### verification/ae_cfg_monitor.sv
// Assertion checker for the exposure configuration bank
`timescale 1ns/1ps
`default_nettype none
module ae_cfg_monitor
   import ae_cfg_pkg::*;
(
   // Clock, reset and write bus
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Loop signals
   input wire logic pixel_in,
   input wire logic filter_valid,
   input wire logic [FILTER_W-1:0] filter_value,
   input wire logic [2:0] gain_req,
   input wire logic stat_take,
   input wire logic [FILTER_W-1:0] filter_state,
   input wire logic [GAIN_W-1:0] gain_stage1,
   input wire logic [GAIN_W-1:0] gain_stage2,
   input wire logic [TARGET_W-1:0] target_intensity,
   input wire logic [CLIP_W-1:0] clip_limit,
   input wire logic [WEIGHT_W-1:0] r_weight,
   input wire logic [WEIGHT_W-1:0] g1_weight,
   input wire logic [WEIGHT_W-1:0] g2_weight
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [ADDR_W-1:0] wa;
   logic [CTL_W-1:0] wd, ctl;
   logic [1:0] pcnt, hi, lo, e1, e2;
   logic hold_q, run_q, exp_take;
   // Bus idle guard keeps checks away from a control update in flight
   wire aw = s_axi_awready;
   wire run = aw && ctl[0] && !ctl[2];
   assign hi = gain_req > 3'd3 ? 2'd3 : gain_req[1:0];
   assign lo = 2'(gain_req - {1'b0, hi});
   // ==========
   // Control mirror
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wa <= '0;
         wd <= '0;
         ctl <= CONTROL_RESET;
      end else begin
         if (s_axi_awvalid && aw) wa <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[CTL_W-1:0];
         if (s_axi_bvalid && s_axi_bready && wa == {2'b00, IDX_CONTROL, 2'b00}) ctl <= wd;
      end
   end
   // ==========
   // Expected loop behaviour
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pcnt <= '0;
         hold_q <= 1'b0;
         run_q <= 1'b0;
         exp_take <= 1'b0;
         e1 <= '0;
         e2 <= '0;
      end else begin
         pcnt <= pcnt + 2'(pixel_in);
         hold_q <= ctl[2] && !ctl[1];
         run_q <= run;
         exp_take <= pixel_in && ctl[0] && (!ctl[3] || pcnt == 2'd0);
         e1 <= ctl[4] ? hi : lo;
         e2 <= ctl[4] ? lo : hi;
      end
   end
   a_freeze_holds_all: assert property (hold_q && ctl[2] && !ctl[1] && aw |=>
      $stable(gain_stage1) && $stable(gain_stage2) && $stable(filter_state))
      else $error("gain or filter moved while frozen");
   a_take_follows_pixel: assert property (aw && $past(aw) |-> stat_take == exp_take)
      else $error("statistics take pulse wrong");
   a_gain_split_order: assert property (run_q && aw |-> gain_stage1 == e1 && gain_stage2 == e2)
      else $error("gain stage distribution wrong");
   a_restart_clears_filter: assert property (aw && ctl[0] && ctl[1] && !ctl[2] |=> filter_state == '0)
      else $error("filter not cleared by restart");
   a_filter_loads_value: assert property (run && !ctl[1] && filter_valid |=>
      filter_state == $past(filter_value))
      else $error("filter value not taken");
   a_target_reset_value: assert property ($rose(reset_n) |->
      target_intensity == 10'h0b8 && clip_limit == 4'h8)
      else $error("target reset value wrong");
   a_weight_reset_value: assert property ($rose(reset_n) |-> r_weight == 10'h080 &&
      g1_weight == 10'h080 && g2_weight == 10'h080)
      else $error("weight reset value wrong");
endmodule
`default_nettype wire

// ### verification/auto_exposure_config_bank_test.sv
// Self-checking bench for the exposure configuration bank
`timescale 1ns/1ps
`default_nettype none
module auto_exposure_config_bank_test import ae_cfg_pkg::*;;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pixel_in = 1'b0, filter_valid = 1'b0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, stat_take;
   logic [1:0] s_axi_bresp, s_axi_rresp, gain_stage1, gain_stage2, rr;
   logic [FILTER_W-1:0] filter_value = '0, filter_state;
   logic [2:0] gain_req = '0;
   logic [TARGET_W-1:0] target_intensity;
   logic [CLIP_W-1:0] clip_limit;
   logic [WEIGHT_W-1:0] r_weight, g1_weight, g2_weight;
   int bad_count = 0, checks = 0;
   always #5 clk = ~clk;
   auto_exposure_config_bank u_auto_exposure_config_bank (.clk, .reset_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pixel_in, .filter_valid,
      .filter_value, .gain_req, .stat_take, .filter_state, .gain_stage1, .gain_stage2,
      .target_intensity, .clip_limit, .r_weight, .g1_weight, .g2_weight);
   function automatic logic [ADDR_W-1:0] ba(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 50) bad_count++;
      @(posedge clk);
   endtask
   task automatic rdreg(input logic [ADDR_W-1:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 50) bad_count++;
      @(posedge clk);
   endtask
   // Eight back-to-back pixels, counting statistics takes
   task automatic burst(input string nm, input int exp);
      int takes;
      takes = 0;
      for (int i = 0; i < 11; i++) begin
         pixel_in <= (i < 8);
         @(posedge clk);
         takes += int'(stat_take === 1'b1);
      end
      chk(nm, exp, takes);
   endtask
   task automatic t_reset;
      logic [31:0] ev [5];
      ev = '{32'h10, 32'h60b8, 32'h80, 32'h80, 32'h80};
      for (int i = 0; i < 5; i++) begin
         rdreg(ba(IDX_CONTROL + 8'(i)));
         chk("reset value", ev[i], rd);
         chk("read resp", 2'h0, rr);
      end
      rdreg(12'h294);
      chk("unmapped read resp", 2'h2, rr);
      chk("target port", 10'h0b8, target_intensity);
      chk("clip port", 4'h8, clip_limit);
      $display("t_reset done");
   endtask
   task automatic t_write;
      logic [31:0] wv [3];
      wv = '{32'hffff_ffff, 32'h0000_0001, 32'h0001_0155};
      wr(ba(IDX_TARGET), 32'h0000_2d37);
      rdreg(ba(IDX_TARGET));
      chk("target read", 32'h2d37, rd);
      chk("target port", 10'h137, target_intensity);
      chk("clip port", 4'hb, clip_limit);
      for (int i = 0; i < 3; i++) begin
         wr(ba(IDX_R_WEIGHT + 8'(i)), wv[i]);
         rdreg(ba(IDX_R_WEIGHT + 8'(i)));
         chk("weight read", wv[i] & 32'h3ff, rd);
      end
      chk("weight ports", {2'b00, 10'h3ff, 10'h001, 10'h155}, {2'b00, r_weight, g1_weight, g2_weight});
      wr(12'h2a0, 32'h1);
      chk("unmapped write resp", 2'h2, rr);
      wr(ba(IDX_STATUS), 32'h0);
      chk("status write resp", 2'h2, rr);
      $display("t_write done");
   endtask
   task automatic t_loop;
      gain_req <= 3'd5;
      wr(ba(IDX_CONTROL), 32'h11);
      chk("stage1 first", {2'd3, 2'd2}, {gain_stage1, gain_stage2});
      burst("every pixel", 8);
      wr(ba(IDX_CONTROL), 32'h09);
      chk("stage2 first", {2'd2, 2'd3}, {gain_stage1, gain_stage2});
      burst("every fourth", 2);
      wr(ba(IDX_CONTROL), 32'h11);
      filter_value <= 16'h1234;
      filter_valid <= 1'b1;
      @(posedge clk);
      filter_valid <= 1'b0;
      repeat (2) @(posedge clk);
      chk("filter load", 16'h1234, filter_state);
      wr(ba(IDX_CONTROL), 32'h15);
      gain_req <= 3'd1;
      filter_value <= 16'h5555;
      filter_valid <= 1'b1;
      repeat (4) @(posedge clk);
      filter_valid <= 1'b0;
      chk("frozen filter", 16'h1234, filter_state);
      chk("frozen gains", {2'd3, 2'd2}, {gain_stage1, gain_stage2});
      wr(ba(IDX_CONTROL), 32'h13);
      repeat (2) @(posedge clk);
      chk("restart filter", 16'h0000, filter_state);
      chk("gains resume", {2'd1, 2'd0}, {gain_stage1, gain_stage2});
      rdreg(ba(IDX_STATUS));
      chk("status word", 32'h0001_0000, rd);
      chk("status resp", 2'h0, rr);
      wr(ba(IDX_CONTROL), 32'h10);
      burst("loop off", 0);
      $display("t_loop done");
   endtask
   task automatic print_verdict;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #200us;
      bad_count++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_write();
      t_loop();
      print_verdict();
   end
endmodule
bind auto_exposure_config_bank ae_cfg_monitor u_ae_cfg_monitor (.clk, .reset_n, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .pixel_in, .filter_valid, .filter_value, .gain_req, .stat_take, .filter_state,
   .gain_stage1, .gain_stage2, .target_intensity, .clip_limit, .r_weight, .g1_weight, .g2_weight);
`default_nettype wire
